// ===== bench/adc_core_model.sv
// Model of the analog core and the clock sources beside it
module adc_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_start,
   input  wire logic        i_async_en,
   input  wire logic [7:0]  i_lat,
   input  wire logic [11:0] i_value,
   output logic             o_done,
   output logic [11:0]      o_result,
   output logic             o_alt,
   output logic             o_async
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   // Result toggles until valid, so an early capture cannot pass
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt <= 8'h00;
         o_done <= 1'b0;
         o_result <= 12'h000;
      end else if (i_start) begin
         cnt <= i_lat;
         o_done <= 1'b0;
         o_result <= ~o_result;
      end else if (cnt == 8'h01) begin
         cnt <= 8'h00;
         o_done <= 1'b1;
         o_result <= i_value;
      end else if (!o_done) begin
         if (cnt != 8'h00) cnt <= cnt - 8'h01;
         o_result <= ~o_result;
      end
   end
   initial begin
      o_alt = 1'b0;
      forever #17 o_alt = ~o_alt;
   end
   // Internal clock runs only on request, like the real generator
   initial begin
      o_async = 1'b0;
      forever #23 o_async = i_async_en ? ~o_async : 1'b0;
   end
endmodule

// ===== bench/adc_ctrl_checker.sv
// Checker: sequencing and pin masking seen at the ports
module adc_ctrl_checker
   import adc_ctrl_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_sys_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_wr,
   input wire logic              i_conv_done,
   input wire logic              o_conv_start,
   input wire logic              o_core_active,
   input wire logic [CHAN_W-1:0] o_conv_channel,
   input wire logic              o_async_clock_enable,
   input wire logic              o_irq,
   input wire logic [PIN_W-1:0]  i_port_oe,
   input wire logic [PIN_W-1:0]  i_port_pullup,
   input wire logic [PIN_W-1:0]  o_pin_oe,
   input wire logic [PIN_W-1:0]  o_pin_pullup_en,
   input wire logic [PIN_W-1:0]  o_pin_analog,
   input wire logic [PIN_W-1:0]  o_port_read
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic [PIN_W-1:0] prev_dis;
   logic [PIN_W-1:0] steady;
   // Bits that just changed are skipped: the mask may lag one cycle
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) prev_dis <= '0;
      else prev_dis <= o_pin_analog;
   end
   assign steady = ~(o_pin_analog ^ prev_dis);
   //////////////////////////////////////////////////////////////
   sequence s_start_req;
      i_wr && i_addr == REG_STATUS_CTRL && i_wdata[CHAN_W-1:0] != CHAN_OFF;
   endsequence
   sequence s_done_seen;
      o_core_active && $rose(i_conv_done);
   endsequence
   a_start_pulse: assert property (s_start_req |=>
      o_conv_start && o_core_active ##1 !o_conv_start)
      else $error("start write gave no single start pulse");
   a_sync_delay: assert property (s_done_seen |->
      o_core_active [*3]) else $error("completion taken unsynchronised");
   a_done_to_idle: assert property (s_done_seen |->
      ##[3:5] !o_core_active) else $error("not idle after completion");
   a_off_idle: assert property (o_conv_channel == CHAN_OFF |->
      !o_core_active && !o_conv_start) else $error("active while off");
   a_irq_idle: assert property ($rose(o_irq) |-> !o_core_active)
      else $error("irq rose without a completion");
   a_async_active: assert property (o_async_clock_enable |->
      o_core_active) else $error("async clock on while idle");
   a_pin_map_hold: assert property (!$past(i_wr) |->
      $stable(o_pin_analog)) else $error("pin map changed alone");
   a_oe_masked: assert property (!$past(i_sys_rst) |->
      (o_pin_oe & steady) == ($past(i_port_oe) & ~o_pin_analog & steady))
      else $error("output enable not masked by pin disable");
   a_pullup_masked: assert property (!$past(i_sys_rst) |->
      (o_pin_pullup_en & steady)
         == ($past(i_port_pullup) & ~o_pin_analog & steady))
      else $error("pullup not masked by pin disable");
   a_read_masked: assert property (
      (o_port_read & o_pin_analog & prev_dis) == '0)
      else $error("disabled pin reads nonzero");
endmodule

bind adc_pin_and_conversion_ctrl adc_ctrl_checker u_chk (.*);

// ===== bench/tb_adc_pin_and_conversion_ctrl.sv
// Testbench: registers, pin masking, clocking and conversions
module tb_adc_pin_and_conversion_ctrl
   import adc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              i_clk, i_sys_rst, i_wr, i_rd, i_low_power_mode;
   logic              i_alternate_clock, i_internal_async_clock;
   logic              i_conv_done, o_conv_start, o_core_active, o_irq;
   logic              o_converter_clock_tick, o_async_clock_enable;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata, lat;
   logic [RAW_W-1:0]  i_conv_result, value;
   logic [CHAN_W-1:0] o_conv_channel;
   logic [1:0]        o_conv_mode;
   logic [PIN_W-1:0]  i_port_out, i_port_oe, i_port_pullup, i_pin_in;
   logic [PIN_W-1:0]  o_pin_out, o_pin_oe, o_pin_pullup_en;
   logic [PIN_W-1:0]  o_pin_analog, o_port_read;
   int                n_mismatch, samples_checked, ticks, e;

   adc_pin_and_conversion_ctrl u_dut (.*);
   adc_core_model u_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_start(o_conv_start), .i_async_en(o_async_clock_enable),
      .i_lat(lat), .i_value(value), .o_done(i_conv_done),
      .o_result(i_conv_result), .o_alt(i_alternate_clock),
      .o_async(i_internal_async_clock));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   //////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, x);
   endtask
   task automatic wait_idle;
      int k = 0;
      #1;
      while (o_core_active !== 1'b0 && k < 500) begin
         @(posedge i_clk);
         #1 k++;
      end
      if (k == 500) begin
         n_mismatch++;
         $display("ERROR %0t: conversion never finished", $time);
         close_out;
      end
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task automatic conv(input logic [1:0] m, input logic en,
                       input logic [11:0] r, input logic [7:0] l,
                       input logic [7:0] h, input logic [7:0] lo);
      lat <= l;
      value <= r;
      wr(REG_CONFIG, {4'h0, m, SRC_BUS});
      wr(REG_STATUS_CTRL, {1'b0, en, 6'h09});
      #1 chk(o_conv_mode, m);
      wait_idle;
      chk(o_irq, en);
      chk(o_converter_clock_tick, 1'b0);
      rd(REG_STATUS_CTRL, {1'b1, en, 6'h09});
      rd(REG_RESULT_HIGH, h);
      rd(REG_RESULT_LOW, lo);
      rd(REG_STATUS_CTRL, {1'b0, en, 6'h09});
   endtask
   //////////////////////////////////////////////////////////////
   initial begin
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_low_power_mode = 1'b0;
      i_port_out = 16'ha5a5;
      i_port_oe = 16'hffff;
      i_port_pullup = 16'hffff;
      i_pin_in = 16'hffff;
      n_mismatch = 0;
      samples_checked = 0;
      i_sys_rst = 1'b1;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      chk(o_core_active, 1'b0);
      rd(REG_STATUS_CTRL, CTRL_RESET);
      rd(REG_CONFIG, CONFIG_RESET);
      rd(4'hf, 8'h00);
      $display("reset test done");
      wr(REG_PIN_DISABLE_CH8_15, 8'h81);
      wr(REG_PIN_DISABLE_CH16_23, 8'h42);
      rd(REG_PIN_DISABLE_CH8_15, 8'h81);
      rd(REG_PIN_DISABLE_CH16_23, 8'h42);
      repeat (4) @(posedge i_clk);
      #1 chk(o_pin_analog, 16'h4281);
      chk(o_pin_oe, 16'hbd7e);
      chk(o_pin_pullup_en, 16'hbd7e);
      chk(o_port_read, 16'hbd7e);
      chk(o_pin_out, 16'ha5a5);
      wr(REG_PIN_DISABLE_CH8_15, 8'h00);
      repeat (4) @(posedge i_clk);
      #1 chk(o_pin_oe, 16'hbdff);
      $display("pin test done");
      lat <= 8'd250;
      for (int s = 0; s < 4; s++)
         for (int d = 0; d < 4; d++) begin
            if (s < 2 || d == 0) begin
               wr(REG_CONFIG, {1'b0, d[1:0], 3'h0, s[1:0]});
               wr(REG_STATUS_CTRL, 8'h09);
               repeat (4) @(posedge i_clk);
               ticks = 0;
               repeat (64) begin
                  @(posedge i_clk);
                  #1 if (o_converter_clock_tick === 1'b1) ticks++;
               end
               e = s < 2 ? 64 / ((s + 1) << d) : (s == 2 ? 19 : 14);
               chk(ticks >= e - 2 && ticks <= e + 2, 1'b1);
               if (s < 2) chk(ticks, e);
               chk(o_async_clock_enable, s == 3);
            end
         end
      i_low_power_mode <= 1'b1;
      repeat (10) @(posedge i_clk);
      #1 chk(o_core_active, 1'b1);
      i_low_power_mode <= 1'b0;
      wr(REG_CONFIG, CONFIG_RESET);
      wr(REG_STATUS_CTRL, 8'h09);
      i_low_power_mode <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1 chk(o_core_active, 1'b0);
      i_low_power_mode <= 1'b0;
      $display("clock test done");
      conv(MODE_12, 1'b1, 12'habc, 8'd3, 8'h0a, 8'hbc);
      conv(MODE_10, 1'b0, 12'h3ff, 8'd40, 8'h01, 8'h00);
      conv(MODE_10, 1'b1, 12'hfff, 8'd3, 8'h03, 8'hff);
      conv(MODE_8, 1'b1, 12'h0ff, 8'd3, 8'h03, 8'h80);
      $display("conversion test done");
      wr(REG_COMPARE_HIGH, 8'h00);
      wr(REG_COMPARE_LOW, 8'h80);
      wr(REG_COMPARE_CTRL, 8'h03);
      value <= 12'h07f;
      wr(REG_CONFIG, {4'h0, MODE_12, SRC_BUS});
      wr(REG_STATUS_CTRL, 8'h09);
      wait_idle;
      rd(REG_STATUS_CTRL, 8'h09);
      rd(REG_RESULT_LOW, 8'h80);
      value <= 12'h090;
      wr(REG_STATUS_CTRL, 8'h09);
      wait_idle;
      rd(REG_STATUS_CTRL, 8'h89);
      rd(REG_RESULT_LOW, 8'h90);
      wr(REG_COMPARE_CTRL, 8'h00);
      $display("compare test done");
      lat <= 8'd100;
      wr(REG_STATUS_CTRL, 8'h09);
      wr(REG_STATUS_CTRL, CTRL_RESET);
      #1 chk(o_core_active, 1'b0);
      chk(o_conv_channel, CHAN_OFF);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(REG_CONFIG, CONFIG_RESET);
      $display("disable test done");
      close_out;
   end
endmodule

// ===== common/adc_ctrl_pkg.sv
// Package: register map, field layout, encodings and reset values
package adc_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int PIN_W  = 16;
   localparam int RAW_W  = 12;
   localparam int CHAN_W = 5;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [ADDR_W-1:0] REG_STATUS_CTRL         = 4'h0;
   localparam logic [ADDR_W-1:0] REG_COMPARE_CTRL        = 4'h1;
   localparam logic [ADDR_W-1:0] REG_RESULT_HIGH         = 4'h2;
   localparam logic [ADDR_W-1:0] REG_RESULT_LOW          = 4'h3;
   localparam logic [ADDR_W-1:0] REG_COMPARE_HIGH        = 4'h4;
   localparam logic [ADDR_W-1:0] REG_COMPARE_LOW         = 4'h5;
   localparam logic [ADDR_W-1:0] REG_CONFIG              = 4'h6;
   localparam logic [ADDR_W-1:0] REG_PIN_DISABLE_CH8_15  = 4'h7;
   localparam logic [ADDR_W-1:0] REG_PIN_DISABLE_CH16_23 = 4'h8;

   ////////////////////////////////////////////////////////////////////////
   localparam int CTRL_FLAG_BIT   = 7;
   localparam int CTRL_IRQ_EN_BIT = 6;
   localparam int CTRL_CHAN_LSB   = 0;
   localparam int CMPC_EN_BIT     = 1;
   localparam int CMPC_GE_BIT     = 0;
   localparam int CFG_DIV_LSB     = 5;
   localparam int CFG_MODE_LSB    = 2;
   localparam int CFG_SRC_LSB     = 0;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h1f;
   localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
   localparam logic [CHAN_W-1:0] CHAN_OFF     = 5'h1f;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [1:0] SRC_BUS      = 2'h0;
   localparam logic [1:0] SRC_BUS_HALF = 2'h1;
   localparam logic [1:0] SRC_ALT      = 2'h2;
   localparam logic [1:0] SRC_ASYNC    = 2'h3;
   localparam logic [1:0] DIV_1        = 2'h0;
   localparam logic [1:0] DIV_2        = 2'h1;
   localparam logic [1:0] DIV_4        = 2'h2;
   localparam logic [1:0] DIV_8        = 2'h3;
   localparam logic [1:0] MODE_8       = 2'h0;
   localparam logic [1:0] MODE_12      = 2'h1;
   localparam logic [1:0] MODE_10      = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   localparam int SYNC_DONE  = 0;
   localparam int SYNC_ALT   = 1;
   localparam int SYNC_ASYNC = 2;
   localparam int SYNC_LOWPW = 3;
   localparam int SYNC_W     = 4;

endpackage

// ===== design/adc_pin_and_conversion_ctrl.sv
// Converter control: registers, conversion sequencing and pin control
//
// Functional notes
// [RL1] Second pin register, bits 7..0 disable channels 15..8.
// [RL2] Third pin register, bits 7..0 disable channels 23..16.
// [RL3] Bit at 0 keeps port control of the pin; 1 disables it.
// [RL4] Converter disabled during reset and while channel select is all ones.
// [RL5] Between conversions the block sits idle at lowest power.
// [RL6] 12- and 10-bit modes take a 12-bit raw result into both bytes.
// [RL7] 8-bit mode takes a 9-bit raw result.
// [RL8] 10-bit mode rounds the raw result to 10 bits.
// [RL9] 8-bit mode rounds to 8 bits, written to the low byte only.
// [RL10] Storing a result sets the complete flag; irq if enabled.
// [RL11] Compare enable checks every result against the compare value.
// [RL12] Two-bit source field picks one of four converter clock sources.
// [RL13] Clock source resets to the undivided bus clock.
// [RL14] Halved bus clock with divide by 8 divides bus clock by 16.
// [RL15] Internal async clock keeps running in wait and stop3.
// [RL16] Selected source is divided by 1, 2, 4 or 8.
// [RL17] Source codes: bus, bus half, alternate, internal async.
// [RL18] Divide codes 00..11 give 1, 2, 4, 8.
// [RL19] Mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// [RL20] Disabled pin: output tri-stated, pullup off, port read zero.
// [RL21] Completion from the converter domain is synchronised first.
module adc_pin_and_conversion_ctrl
   import adc_ctrl_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   input  wire logic              i_alternate_clock,
   input  wire logic              i_internal_async_clock,
   input  wire logic              i_low_power_mode,
   input  wire logic              i_conv_done,
   input  wire logic [RAW_W-1:0]  i_conv_result,
   output logic                   o_conv_start,
   output logic                   o_core_active,
   output logic      [CHAN_W-1:0] o_conv_channel,
   output logic      [1:0]        o_conv_mode,
   output logic                   o_converter_clock_tick,
   output logic                   o_async_clock_enable,
   output logic                   o_irq,
   input  wire logic [PIN_W-1:0]  i_port_out,
   input  wire logic [PIN_W-1:0]  i_port_oe,
   input  wire logic [PIN_W-1:0]  i_port_pullup,
   input  wire logic [PIN_W-1:0]  i_pin_in,
   output logic      [PIN_W-1:0]  o_pin_out,
   output logic      [PIN_W-1:0]  o_pin_oe,
   output logic      [PIN_W-1:0]  o_pin_pullup_en,
   output logic      [PIN_W-1:0]  o_pin_analog,
   output logic      [PIN_W-1:0]  o_port_read
);

   typedef enum logic [1:0] {
      ST_DISABLED,
      ST_IDLE,
      ST_CONVERT
   } conv_state_e;

   typedef struct packed {
      conv_state_e       state;
      logic [DATA_W-1:0] ctrl;
      logic              flag;
      logic [1:0]        cmp_ctrl;
      logic [DATA_W-1:0] cfg;
      logic [DATA_W-1:0] cmp_high;
      logic [DATA_W-1:0] cmp_low;
      logic [DATA_W-1:0] res_high;
      logic [DATA_W-1:0] res_low;
      logic [DATA_W-1:0] pin_lo;
      logic [DATA_W-1:0] pin_hi;
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic              done_prev;
      logic [RAW_W-1:0]  res_sync1;
      logic [RAW_W-1:0]  res_sync2;
      logic [PIN_W-1:0]  pin_sync1;
      logic [PIN_W-1:0]  pin_sync2;
      logic [PIN_W-1:0]  pin_out;
      logic [PIN_W-1:0]  pin_oe;
      logic [PIN_W-1:0]  pin_pullup;
      logic [PIN_W-1:0]  port_read;
      logic [DATA_W-1:0] rdata;
      logic              irq;
      logic              start;
      logic              active;
      logic              async_en;
   } ctrl_state_s;

   localparam ctrl_state_s RESET_STATE = '{
      state:   ST_DISABLED,
      ctrl:    CTRL_RESET,
      cfg:     CONFIG_RESET,
      default: '0
   };

   ctrl_state_s       q;
   ctrl_state_s       next_q;
   logic [1:0]        source;
   logic [1:0]        divide;
   logic [1:0]        mode;
   logic [CHAN_W-1:0] channel;
   logic [PIN_W-1:0]  pin_disable;
   logic              tick;
   logic [DATA_W-1:0] fmt_high;
   logic [DATA_W-1:0] fmt_low;
   logic [RAW_W-1:0]  fmt_value;
   logic              fmt_write_high;
   logic [RAW_W-1:0]  cmp_value;
   logic              cmp_match;
   logic              done_edge;
   logic              store;
   logic              flag_clear;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input logic [ADDR_W-1:0] a);
      hit = (i_addr == a);
   endfunction

   function automatic logic [DATA_W-1:0] read_mux(
      input ctrl_state_s s,
      input logic [ADDR_W-1:0] a
   );
      case (a)
         REG_STATUS_CTRL: begin
            read_mux = s.ctrl;
            read_mux[CTRL_FLAG_BIT] = s.flag;
         end
         REG_COMPARE_CTRL:        read_mux = {6'h00, s.cmp_ctrl};
         REG_RESULT_HIGH:         read_mux = s.res_high;
         REG_RESULT_LOW:          read_mux = s.res_low;
         REG_COMPARE_HIGH:        read_mux = s.cmp_high;
         REG_COMPARE_LOW:         read_mux = s.cmp_low;
         REG_CONFIG:              read_mux = s.cfg;
         REG_PIN_DISABLE_CH8_15:  read_mux = s.pin_lo;
         REG_PIN_DISABLE_CH16_23: read_mux = s.pin_hi;
         default:                 read_mux = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign source      = q.cfg[CFG_SRC_LSB +: 2];
   assign divide      = q.cfg[CFG_DIV_LSB +: 2];
   assign mode        = q.cfg[CFG_MODE_LSB +: 2];
   assign channel     = q.ctrl[CTRL_CHAN_LSB +: CHAN_W];
   assign pin_disable = {q.pin_hi, q.pin_lo}; // [RL1] [RL2]

   converter_clock_gen u_clock_gen (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_run        (q.active),
      .i_source     (source),
      .i_divide     (divide),
      .i_alt_sync   (q.sync2[SYNC_ALT]),
      .i_async_sync (q.sync2[SYNC_ASYNC]),
      .o_tick       (tick)
   );

   result_format u_format (
      .i_raw        (q.res_sync2),
      .i_mode       (mode),
      .o_high       (fmt_high),
      .o_low        (fmt_low),
      .o_value      (fmt_value),
      .o_write_high (fmt_write_high)
   );

   // Compare width follows the mode; the unused high bits are ignored
   always_comb begin
      case (mode)
         MODE_8:  cmp_value = {4'h0, q.cmp_low};
         MODE_10: cmp_value = {2'h0, q.cmp_high[1:0], q.cmp_low};
         default: cmp_value = {q.cmp_high[3:0], q.cmp_low};
      endcase
      if (q.cmp_ctrl[CMPC_GE_BIT]) begin
         cmp_match = (fmt_value >= cmp_value);
      end else begin
         cmp_match = (fmt_value < cmp_value);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Raw result is synchronised beside done, steady while done stays high
   assign done_edge = q.sync2[SYNC_DONE] & ~q.done_prev; // [RL21]
   assign store     = (q.state == ST_CONVERT) && done_edge &&
                      (!q.cmp_ctrl[CMPC_EN_BIT] || cmp_match); // [RL11]
   assign flag_clear = (i_wr && i_addr == REG_STATUS_CTRL) ||
                       (i_rd && i_addr == REG_RESULT_LOW);

   always_comb begin
      next_q           = q;
      next_q.sync1     = {i_low_power_mode, i_internal_async_clock,
                          i_alternate_clock, i_conv_done};
      next_q.sync2     = q.sync1;
      next_q.done_prev = q.sync2[SYNC_DONE];
      next_q.pin_sync1 = i_pin_in;
      next_q.pin_sync2 = q.pin_sync1;
      next_q.res_sync1 = i_conv_result; // [RL21]
      next_q.res_sync2 = q.res_sync1;
      next_q.start     = 1'b0;
      next_q.rdata     = 8'h00;

      if (i_rd) begin
         next_q.rdata = read_mux(q, i_addr);
      end

      // Register writes; a compare or config register write aborts a conversion
      if (i_wr) begin
         case (i_addr)
            REG_STATUS_CTRL:         next_q.ctrl     = i_wdata;
            REG_COMPARE_CTRL:        next_q.cmp_ctrl = i_wdata[1:0];
            REG_COMPARE_HIGH:        next_q.cmp_high = i_wdata;
            REG_COMPARE_LOW:         next_q.cmp_low  = i_wdata;
            REG_CONFIG:              next_q.cfg      = i_wdata;
            REG_PIN_DISABLE_CH8_15:  next_q.pin_lo   = i_wdata; // [RL1]
            REG_PIN_DISABLE_CH16_23: next_q.pin_hi   = i_wdata; // [RL2]
            default:                 next_q.ctrl     = q.ctrl;
         endcase
      end

      case (q.state)
         ST_DISABLED: begin
            next_q.state = ST_DISABLED;
         end
         ST_IDLE: begin
            next_q.state = ST_IDLE; // [RL5]
         end
         ST_CONVERT: begin
            // Stop with any source but the internal async clock kills the converter clock
            if (q.sync2[SYNC_LOWPW] && source != SRC_ASYNC) begin // [RL15]
               next_q.state = ST_IDLE;
            end else if (done_edge) begin
               next_q.state = ST_IDLE; // [RL5]
            end
         end
         default: begin
            next_q.state = ST_DISABLED;
         end
      endcase

      if (i_wr && (hit(REG_COMPARE_CTRL) || hit(REG_COMPARE_HIGH) ||
                   hit(REG_COMPARE_LOW) || hit(REG_CONFIG))) begin
         if (q.state == ST_CONVERT) begin
            next_q.state = ST_IDLE;
         end
      end

      // A control write restarts, unless it selects the all-ones channel
      if (i_wr && hit(REG_STATUS_CTRL)) begin
         if (i_wdata[CTRL_CHAN_LSB +: CHAN_W] == CHAN_OFF) begin
            next_q.state = ST_DISABLED; // [RL4]
         end else begin
            next_q.state = ST_CONVERT;
            next_q.start = 1'b1;
         end
      end

      if (store) begin
         next_q.res_low = fmt_low; // [RL6] [RL9]
         if (fmt_write_high) begin
            next_q.res_high = fmt_high; // [RL8]
         end
      end

      // A completion in the clearing cycle keeps the flag set
      if (store) begin
         next_q.flag = 1'b1; // [RL10]
      end else if (flag_clear) begin
         next_q.flag = 1'b0;
      end

      next_q.irq      = next_q.flag & next_q.ctrl[CTRL_IRQ_EN_BIT]; // [RL10]
      next_q.active   = (next_q.state == ST_CONVERT); // [RL4] [RL5]
      next_q.async_en = next_q.active && source == SRC_ASYNC; // [RL15]

      // Pin gating follows the disable bits one cycle after a write
      next_q.pin_out    = i_port_out;
      next_q.pin_oe     = i_port_oe & ~pin_disable; // [RL3] [RL20]
      next_q.pin_pullup = i_port_pullup & ~pin_disable; // [RL20]
      next_q.port_read  = q.pin_sync2 & ~pin_disable; // [RL20]
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= RESET_STATE; // [RL4] [RL13]
      end else begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_rdata                = q.rdata;
   assign o_conv_start           = q.start;
   assign o_core_active          = q.active;
   assign o_conv_channel         = channel;
   assign o_conv_mode            = mode;
   assign o_converter_clock_tick = tick;
   assign o_async_clock_enable   = q.async_en;
   assign o_irq                  = q.irq;
   assign o_pin_out              = q.pin_out;
   assign o_pin_oe               = q.pin_oe;
   assign o_pin_pullup_en        = q.pin_pullup;
   assign o_pin_analog           = pin_disable;
   assign o_port_read            = q.port_read;

endmodule

// ===== design/converter_clock_gen.sv
// Converter clock tick generator: source select and 1/2/4/8 divider
module converter_clock_gen
   import adc_ctrl_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_run,
   input  wire logic [1:0] i_source,
   input  wire logic [1:0] i_divide,
   input  wire logic       i_alt_sync,
   input  wire logic       i_async_sync,
   output logic            o_tick
);

   typedef struct packed {
      logic       half;
      logic       alt_prev;
      logic       async_prev;
      logic [2:0] count;
      logic       tick;
   } div_state_s;

   div_state_s q;
   div_state_s next_q;
   logic       src_tick;

   function automatic logic [2:0] terminal(input logic [1:0] code);
      case (code)
         DIV_1:   terminal = 3'h0;
         DIV_2:   terminal = 3'h1;
         DIV_4:   terminal = 3'h3;
         default: terminal = 3'h7;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_q            = q;
      next_q.half       = ~q.half;
      next_q.alt_prev   = i_alt_sync;
      next_q.async_prev = i_async_sync;
      next_q.tick       = 1'b0;
      case (i_source) // [RL12] [RL17]
         SRC_BUS:      src_tick = 1'b1;
         SRC_BUS_HALF: src_tick = q.half;
         SRC_ALT:      src_tick = i_alt_sync & ~q.alt_prev;
         default:      src_tick = i_async_sync & ~q.async_prev;
      endcase
      if (!i_run) begin
         next_q.count = 3'h0;
         next_q.half  = 1'b0;
      end else if (src_tick) begin
         // Halved source with divide by 8 gives one tick per 16 cycles
         if (q.count >= terminal(i_divide)) begin // [RL16] [RL18] [RL14]
            next_q.count = 3'h0;
            next_q.tick  = 1'b1;
         end else begin
            next_q.count = q.count + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_tick = q.tick;

endmodule

// ===== design/result_format.sv
// Result rounding and placement into the high and low result bytes
module result_format
   import adc_ctrl_pkg::*;
(
   input  wire logic [RAW_W-1:0]  i_raw,
   input  wire logic [1:0]        i_mode,
   output logic      [DATA_W-1:0] o_high,
   output logic      [DATA_W-1:0] o_low,
   output logic      [RAW_W-1:0]  o_value,
   output logic                   o_write_high
);

   logic [10:0] sum10;
   logic [8:0]  sum8;
   logic [9:0]  r10;
   logic [7:0]  r8;

   // Rounding saturates so a full-scale code never wraps to zero
   always_comb begin
      sum10 = {1'b0, i_raw[11:2]} + {10'h000, i_raw[1]};
      r10   = sum10[10] ? 10'h3ff : sum10[9:0]; // [RL8]
      sum8  = {1'b0, i_raw[8:1]} + {8'h00, i_raw[0]};
      r8    = sum8[8] ? 8'hff : sum8[7:0]; // [RL7] [RL9]
      case (i_mode) // [RL19]
         MODE_8: begin
            o_value      = {4'h0, r8};
            o_high       = 8'h00;
            o_low        = r8;
            o_write_high = 1'b0; // [RL9]
         end
         MODE_10: begin
            o_value      = {2'h0, r10};
            o_high       = {6'h00, r10[9:8]};
            o_low        = r10[7:0];
            o_write_high = 1'b1;
         end
         default: begin
            o_value      = i_raw;
            o_high       = {4'h0, i_raw[11:8]}; // [RL6]
            o_low        = i_raw[7:0];
            o_write_high = 1'b1;
         end
      endcase
   end

endmodule
